/* File: rtl/chan0_config_calibration_regs.v */
// Channel 0 setup and calibration registers behind an APB slave, with correction datapath
// Function
// - Ten-bit delay field in setup bits 15:6
// - Delay field is signed two's complement
// - Setup bits 5:3 read zero, not writable
// - Bypass bit disables DC removal for channel
// - Global DC removal setting, four bits, default zero
// - Two-bit selector picks pins, short, test
// - Offset upper register holds offset bits 23:8
// - Offset bits 7:0 in lower bits 15:8
// - Lower calibration bits 7:0 read zero
// - Gain unsigned 24 bits, upper register 23:8
// - Gain bits 7:0 in lower bits 15:8
// - Gain upper register resets to 8000h
// - Setup register resets to 0000h
`timescale 1ns/10ps
`default_nettype none
`include "chan0_regs_defs.vh"

module chan0_config_calibration_regs #(
   parameter DATA_WIDTH = 24
) (
   input  wire                         i_clock,
   input  wire                         i_reset_n,
   input  wire                         i_psel,
   input  wire                         i_penable,
   input  wire                         i_pwrite,
   input  wire [31:0]                  i_paddr,
   input  wire [31:0]                  i_pwdata,
   input  wire [3:0]                   i_pstrb,
   output wire                         o_pready,
   output reg  [31:0]                  o_prdata,
   output wire                         o_pslverr,
   input  wire                         i_sample_valid,
   input  wire signed [DATA_WIDTH-1:0] i_sample,
   output reg                          o_result_valid,
   output reg  signed [DATA_WIDTH-1:0] o_result,
   output reg  signed [9:0]            o_chan0_delay_cycles,
   output reg                          o_chan0_dc_removal_active,
   output reg  [3:0]                   o_global_dc_removal_setting,
   output reg  [1:0]                   o_chan0_input_select,
   output reg                          o_route_own_pins,
   output reg                          o_route_shorted,
   output reg                          o_route_test_pos,
   output reg                          o_route_test_neg
);

   reg [9:0]  chan0_delay_cycles;
   reg        chan0_dc_removal_bypass;
   reg [1:0]  chan0_input_select;
   reg [15:0] chan0_offset_high_part;
   reg [7:0]  chan0_offset_low_part;
   reg [15:0] chan0_gain_high_part;
   reg [7:0]  chan0_gain_low_part;
   reg [3:0]  global_dc_removal_setting;
   reg [15:0] global_setup_high;
   reg [15:0] chan1_setup;
   reg [9:0]  next_delay_cycles;
   reg        next_bypass;
   reg [1:0]  next_select;
   reg [15:0] next_offset_high_part;
   reg [7:0]  next_offset_low_part;
   reg [15:0] next_gain_high_part;
   reg [7:0]  next_gain_low_part;
   reg [3:0]  next_global_setting;
   reg [15:0] next_global_high;
   reg [15:0] next_chan1_setup;

   // Setup field reset values, cut from the register's reset word
   localparam [15:0] SETUP_RESET  = `RST_SETUP;
   localparam [9:0]  DELAY_RESET  = SETUP_RESET[`DELAY_MSB:`DELAY_LSB];
   localparam [0:0]  BYPASS_RESET = SETUP_RESET[`BYPASS_BIT];
   localparam [1:0]  SELECT_RESET = SETUP_RESET[`SELECT_MSB:`SELECT_LSB];

   // Writable bits: spare bits of these registers stay zero
   localparam [15:0] GLOBAL_KEEP  = 16'hFF00;
   localparam [15:0] SETUP_KEEP   = 16'hFFC7;

   wire        access  = i_psel & i_penable;
   wire        wr_en   = access & i_pwrite;
   wire [7:0]  index   = i_paddr[9:2];
   wire        aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[31:10] == 22'h000000);
   reg         mapped;
   reg  [15:0] read_word;
   wire        setup_rd = i_psel & ~i_penable & ~i_pwrite;

   // Byte lane merge for a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] wdata;
      input [1:0]  strb;
      begin
         merge16 = {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
      end
   endfunction

   // Byte lane merge for the stored byte of a lower calibration register
   function [7:0] merge_low;
      input [7:0]  old;
      input [15:0] wdata;
      input        strb;
      begin
         merge_low = strb ? wdata[`LOW_PART_MSB:`LOW_PART_LSB] : old;
      end
   endfunction

   // Read word of a lower calibration register, spare byte zero
   function [15:0] low_word;
      input [7:0] part;
      begin
         low_word = {part, 8'h00};
      end
   endfunction

   // Read word of a setup register, spare bits zero
   function [15:0] setup_word;
      input [15:0] fields;
      begin
         setup_word = {fields[`DELAY_MSB:`DELAY_LSB], 3'h0, fields[`BYPASS_BIT:`SELECT_LSB]};
      end
   endfunction

   // Route decode, one output per selector code
   function select_is;
      input [1:0] sel;
      input [1:0] code;
      begin
         select_is = (sel == code);
      end
   endfunction

   assign o_pready  = 1'b1;
   assign o_pslverr = access & ~mapped;

   always @* begin
      mapped    = aligned;
      read_word = 16'h0000;
      case (index)
         `IDX_GLOBAL_SETUP:    read_word = {global_setup_high[15:4],
                                            global_dc_removal_setting};
         `IDX_CHAN0_SETUP:     read_word = setup_word({chan0_delay_cycles, 3'h0,
                                                       chan0_dc_removal_bypass,
                                                       chan0_input_select});
         `IDX_CHAN0_OFFSET_UP: read_word = chan0_offset_high_part;
         `IDX_CHAN0_OFFSET_LO: read_word = low_word(chan0_offset_low_part);
         `IDX_CHAN0_GAIN_UP:   read_word = chan0_gain_high_part;
         `IDX_CHAN0_GAIN_LO:   read_word = low_word(chan0_gain_low_part);
         `IDX_CHAN1_SETUP:     read_word = setup_word(chan1_setup);
         default:              mapped = 1'b0;
      endcase
   end

   // Next values of the stored fields; a refused access leaves them as they are
   always @* begin
      next_delay_cycles     = chan0_delay_cycles;
      next_bypass           = chan0_dc_removal_bypass;
      next_select           = chan0_input_select;
      next_offset_high_part = chan0_offset_high_part;
      next_offset_low_part  = chan0_offset_low_part;
      next_gain_high_part   = chan0_gain_high_part;
      next_gain_low_part    = chan0_gain_low_part;
      next_global_setting   = global_dc_removal_setting;
      next_global_high      = global_setup_high;
      next_chan1_setup      = chan1_setup;
      if (wr_en && mapped) begin
         case (index)
            `IDX_GLOBAL_SETUP: begin
               next_global_high = merge16(global_setup_high, i_pwdata[15:0],
                                          i_pstrb[1:0]) & GLOBAL_KEEP;
               if (i_pstrb[0]) begin
                  next_global_setting = i_pwdata[`GLOBAL_DC_MSB:`GLOBAL_DC_LSB];
               end
            end
            `IDX_CHAN0_SETUP: begin
               if (i_pstrb[1]) begin
                  next_delay_cycles[9:2] = i_pwdata[`DELAY_MSB:8];
               end
               if (i_pstrb[0]) begin
                  next_delay_cycles[1:0] = i_pwdata[7:`DELAY_LSB];
                  next_bypass            = i_pwdata[`BYPASS_BIT];
                  next_select            = i_pwdata[`SELECT_MSB:`SELECT_LSB];
               end
            end
            `IDX_CHAN0_OFFSET_UP: begin
               next_offset_high_part = merge16(chan0_offset_high_part, i_pwdata[15:0],
                                               i_pstrb[1:0]);
            end
            `IDX_CHAN0_OFFSET_LO: begin
               next_offset_low_part = merge_low(chan0_offset_low_part, i_pwdata[15:0],
                                                i_pstrb[1]);
            end
            `IDX_CHAN0_GAIN_UP: begin
               next_gain_high_part = merge16(chan0_gain_high_part, i_pwdata[15:0],
                                             i_pstrb[1:0]);
            end
            `IDX_CHAN0_GAIN_LO: begin
               next_gain_low_part = merge_low(chan0_gain_low_part, i_pwdata[15:0],
                                              i_pstrb[1]);
            end
            `IDX_CHAN1_SETUP: begin
               next_chan1_setup = merge16(chan1_setup, i_pwdata[15:0], i_pstrb[1:0])
                                  & SETUP_KEEP;
            end
            default: ;
         endcase
      end
   end

   // Read data is loaded in the setup cycle so that it stands in the access cycle
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_prdata <= 32'h00000000;
      end else if (setup_rd) begin
         o_prdata <= {16'h0000, mapped ? read_word : 16'h0000};
      end
   end

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         chan0_delay_cycles        <= DELAY_RESET;
         chan0_dc_removal_bypass   <= BYPASS_RESET;
         chan0_input_select        <= SELECT_RESET;
         chan0_offset_high_part    <= `RST_OFFSET_UP;
         chan0_offset_low_part     <= `RST_LOW_PART;
         chan0_gain_high_part      <= `RST_GAIN_UP;
         chan0_gain_low_part       <= `RST_LOW_PART;
         global_dc_removal_setting <= `RST_GLOBAL_DC;
         global_setup_high         <= 16'h0000;
         chan1_setup               <= `RST_SETUP;
      end else begin
         chan0_delay_cycles        <= next_delay_cycles;
         chan0_dc_removal_bypass   <= next_bypass;
         chan0_input_select        <= next_select;
         chan0_offset_high_part    <= next_offset_high_part;
         chan0_offset_low_part     <= next_offset_low_part;
         chan0_gain_high_part      <= next_gain_high_part;
         chan0_gain_low_part       <= next_gain_low_part;
         global_dc_removal_setting <= next_global_setting;
         global_setup_high         <= next_global_high;
         chan1_setup               <= next_chan1_setup;
      end
   end

   // Correction datapath: subtract offset, multiply by gain (1.23 unsigned)
   wire signed [23:0] offset_value = {chan0_offset_high_part, chan0_offset_low_part};
   wire        [23:0] gain_value   = {chan0_gain_high_part, chan0_gain_low_part};
   wire signed [DATA_WIDTH+1:0] sample_ext = {{2{i_sample[DATA_WIDTH-1]}}, i_sample};
   wire signed [DATA_WIDTH+1:0] offset_ext = {{(DATA_WIDTH-22){offset_value[23]}},
                                              offset_value};
   wire signed [DATA_WIDTH+1:0] corrected  = sample_ext - offset_ext;
   wire signed [DATA_WIDTH+26:0] scaled = corrected * $signed({1'b0, gain_value});
   wire signed [DATA_WIDTH+3:0]  shifted = scaled[DATA_WIDTH+26:23];
   localparam signed [DATA_WIDTH+3:0] MAX_VAL = {4'h0, 1'b0, {(DATA_WIDTH-1){1'b1}}};
   localparam signed [DATA_WIDTH+3:0] MIN_VAL = {4'hF, 1'b1, {(DATA_WIDTH-1){1'b0}}};
   reg signed [DATA_WIDTH-1:0] next_result;

   always @* begin
      if (shifted > MAX_VAL) begin
         next_result = MAX_VAL[DATA_WIDTH-1:0];
      end else if (shifted < MIN_VAL) begin
         next_result = MIN_VAL[DATA_WIDTH-1:0];
      end else begin
         next_result = shifted[DATA_WIDTH-1:0];
      end
   end

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_result_valid <= 1'b0;
         o_result       <= {DATA_WIDTH{1'b0}};
      end else begin
         o_result_valid <= i_sample_valid;
         if (i_sample_valid) begin
            o_result <= next_result;
         end
      end
   end

   // Control outputs lag the stored fields by one clock
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_chan0_delay_cycles        <= 10'h000;
         o_chan0_dc_removal_active   <= 1'b0;
         o_global_dc_removal_setting <= 4'h0;
         o_chan0_input_select        <= `SEL_PINS;
         o_route_own_pins            <= 1'b1;
         o_route_shorted             <= 1'b0;
         o_route_test_pos            <= 1'b0;
         o_route_test_neg            <= 1'b0;
      end else begin
         o_chan0_delay_cycles <= $signed(chan0_delay_cycles);
         // Active when global setting nonzero and not bypassed
         o_chan0_dc_removal_active <= ~chan0_dc_removal_bypass
                                      & (global_dc_removal_setting != 4'h0);
         o_global_dc_removal_setting <= global_dc_removal_setting;
         o_chan0_input_select <= chan0_input_select;
         o_route_own_pins     <= select_is(chan0_input_select, `SEL_PINS);
         o_route_shorted      <= select_is(chan0_input_select, `SEL_SHORTED);
         o_route_test_pos     <= select_is(chan0_input_select, `SEL_TEST_POS);
         o_route_test_neg     <= select_is(chan0_input_select, `SEL_TEST_NEG);
      end
   end

endmodule // chan0_config_calibration_regs
`default_nettype wire

/* File: rtl/chan0_regs_defs.vh */
// Register offsets, field positions and reset values for the channel 0 register bank
`ifndef CHAN0_REGS_DEFS_VH
`define CHAN0_REGS_DEFS_VH

// Printed offsets are register indices; byte address is index times four
`define IDX_GLOBAL_SETUP      8'h08
`define IDX_CHAN0_SETUP       8'h09
`define IDX_CHAN0_OFFSET_UP   8'h0A
`define IDX_CHAN0_OFFSET_LO   8'h0B
`define IDX_CHAN0_GAIN_UP     8'h0C
`define IDX_CHAN0_GAIN_LO     8'h0D
`define IDX_CHAN1_SETUP       8'h0E

`define DELAY_MSB             15
`define DELAY_LSB             6
`define BYPASS_BIT            2
`define SELECT_MSB            1
`define SELECT_LSB            0
`define LOW_PART_MSB          15
`define LOW_PART_LSB          8
`define GLOBAL_DC_MSB         3
`define GLOBAL_DC_LSB         0

`define RST_SETUP             16'h0000
`define RST_OFFSET_UP         16'h0000
`define RST_LOW_PART          8'h00
`define RST_GAIN_UP           16'h8000
`define RST_GLOBAL_DC         4'h0

`define SEL_PINS              2'h0
`define SEL_SHORTED           2'h1
`define SEL_TEST_POS          2'h2
`define SEL_TEST_NEG          2'h3

`endif

/* File: dv/chan0_regs_asserts.sv */
// Concurrent checks on the ports of the channel 0 register bank
`timescale 1ns/10ps
`default_nettype none
module chan0_regs_checker (
   input wire logic              i_clock,
   input wire logic              i_reset_n,
   input wire logic              i_psel,
   input wire logic              i_penable,
   input wire logic              i_pwrite,
   input wire logic [31:0]       i_paddr,
   input wire logic [31:0]       i_pwdata,
   input wire logic [31:0]       o_prdata,
   input wire logic              i_sample_valid,
   input wire logic              o_result_valid,
   input wire logic signed [9:0] o_chan0_delay_cycles,
   input wire logic              o_chan0_dc_removal_active,
   input wire logic [3:0]        o_global_dc_removal_setting,
   input wire logic [1:0]        o_chan0_input_select,
   input wire logic              o_route_own_pins,
   input wire logic              o_route_shorted,
   input wire logic              o_route_test_pos,
   input wire logic              o_route_test_neg
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   wire wr_acc = i_psel & i_penable & i_pwrite;
   wire rd_acc = i_psel & i_penable & ~i_pwrite;
   chk_setup_rsvd: assert property (
      rd_acc && i_paddr == 32'h24 |-> o_prdata[5:3] == 3'h0) else $error("setup spare bits set");
   chk_lower_rsvd: assert property (
      rd_acc && (i_paddr == 32'h2C || i_paddr == 32'h34) |-> o_prdata[7:0] == 8'h00)
      else $error("lower spare bits set");
   chk_delay_load: assert property (
      wr_acc && i_paddr == 32'h24 |-> ##2 o_chan0_delay_cycles == $past(i_pwdata[15:6], 2))
      else $error("delay not loaded");
   chk_bypass_off: assert property (
      wr_acc && i_paddr == 32'h24 && i_pwdata[2] |-> ##2 !o_chan0_dc_removal_active)
      else $error("bypass ignored");
   chk_global_load: assert property (
      wr_acc && i_paddr == 32'h20 |-> ##2 o_global_dc_removal_setting == $past(i_pwdata[3:0], 2))
      else $error("global setting not loaded");
   chk_route_onehot: assert property (
      {o_route_test_neg, o_route_test_pos, o_route_shorted, o_route_own_pins}
      == 4'h1 << o_chan0_input_select) else $error("route decode wrong");
   chk_result_pulse: assert property (
      i_sample_valid |=> o_result_valid) else $error("result missing");
   chk_result_quiet: assert property (
      !i_sample_valid |=> !o_result_valid) else $error("spurious result");
   chk_reset_setup: assert property (
      $rose(i_reset_n) |-> o_chan0_delay_cycles == 10'h000 && o_route_own_pins)
      else $error("setup not reset");
   cover property (wr_acc && i_paddr == 32'h24);
   cover property (rd_acc && i_paddr == 32'h2C);
   cover property (o_result_valid);
endmodule // chan0_regs_checker
bind chan0_config_calibration_regs chan0_regs_checker chk (.i_clock(i_clock),
   .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .i_sample_valid(i_sample_valid), .o_result_valid(o_result_valid),
   .o_chan0_delay_cycles(o_chan0_delay_cycles),
   .o_chan0_dc_removal_active(o_chan0_dc_removal_active),
   .o_global_dc_removal_setting(o_global_dc_removal_setting),
   .o_chan0_input_select(o_chan0_input_select), .o_route_own_pins(o_route_own_pins),
   .o_route_shorted(o_route_shorted), .o_route_test_pos(o_route_test_pos),
   .o_route_test_neg(o_route_test_neg));
`default_nettype wire

/* File: dv/chan0_config_calibration_regs_tb.sv */
// Self-checking bench for the channel 0 register bank
`timescale 1ns/10ps
`default_nettype none
module chan0_config_calibration_regs_tb;
   logic        i_clock = 1'b0, i_reset_n = 1'b0, i_sample_valid = 1'b0;
   logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, o_prdata, rd;
   logic [3:0]  i_pstrb = 4'hF, o_global_dc_removal_setting;
   logic [23:0] i_sample = 24'h0, o_result;
   logic [9:0]  o_chan0_delay_cycles;
   logic [1:0]  o_chan0_input_select;
   logic        o_pready, o_pslverr, o_result_valid, o_chan0_dc_removal_active, err;
   logic        o_route_own_pins, o_route_shorted, o_route_test_pos, o_route_test_neg;
   int          failures = 0, checks_done = 0;
   always #20 i_clock = ~i_clock;
   chan0_config_calibration_regs dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata),
      .o_pslverr(o_pslverr), .i_sample_valid(i_sample_valid), .i_sample(i_sample),
      .o_result_valid(o_result_valid), .o_result(o_result),
      .o_chan0_delay_cycles(o_chan0_delay_cycles),
      .o_chan0_dc_removal_active(o_chan0_dc_removal_active),
      .o_global_dc_removal_setting(o_global_dc_removal_setting),
      .o_chan0_input_select(o_chan0_input_select), .o_route_own_pins(o_route_own_pins),
      .o_route_shorted(o_route_shorted), .o_route_test_pos(o_route_test_pos),
      .o_route_test_neg(o_route_test_neg));
   task check(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Read data and error are taken at the access edge at which pready is high
   task apb(input logic wr, input logic [31:0] a, d);
      i_psel <= 1'b1; i_pwrite <= wr; i_paddr <= a; i_pwdata <= d;
      @(posedge i_clock) i_penable <= 1'b1;
      @(posedge i_clock);
      while (o_pready !== 1'b1) @(posedge i_clock);
      err = o_pslverr;
      rd = o_prdata;
      i_psel <= 1'b0; i_penable <= 1'b0;
      @(posedge i_clock);
   endtask
   task wr_chk(input logic [31:0] a, d, exp, input string what);
      apb(1'b1, a, d); apb(1'b0, a, 32'h0); check(what, exp, rd);
   endtask
   task sample(input logic [23:0] s, exp);
      i_sample_valid <= 1'b1; i_sample <= s;
      @(posedge i_clock) i_sample_valid <= 1'b0;
      @(posedge i_clock);
      check("result valid", 32'h1, o_result_valid);
      check("result", exp, o_result);
      @(posedge i_clock);
   endtask
   task test_reset;
      apb(1'b0, 32'h24, 32'h0); check("setup", 32'h0, rd);
      apb(1'b0, 32'h28, 32'h0); check("offset up", 32'h0, rd);
      apb(1'b0, 32'h30, 32'h0); check("gain up", 32'h8000, rd);
      apb(1'b0, 32'h20, 32'h0); check("global", 32'h0, rd);
      check("own pins", 32'h1, o_route_own_pins);
      $display("test_reset done");
   endtask
   task test_setup;
      wr_chk(32'h24, 32'hFFFF, 32'hFFC7, "setup spare");
      check("delay", 32'h3FF, o_chan0_delay_cycles);
      check("delay sign", 32'h1, $signed(o_chan0_delay_cycles) < 0);
      apb(1'b1, 32'h20, 32'h5); apb(1'b1, 32'h24, 32'h0); @(posedge i_clock);
      check("dc active", 32'h1, o_chan0_dc_removal_active);
      check("global out", 32'h5, o_global_dc_removal_setting);
      apb(1'b1, 32'h24, 32'h4); @(posedge i_clock);
      check("dc bypass", 32'h0, o_chan0_dc_removal_active);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 32'h24, k); @(posedge i_clock);
         check("route", 32'h1 << k, {o_route_test_neg, o_route_test_pos,
            o_route_shorted, o_route_own_pins});
         check("select", k, o_chan0_input_select);
      end
      $display("test_setup done");
   endtask
   task test_cal;
      wr_chk(32'h2C, 32'hFFFF, 32'hFF00, "offset lo");
      wr_chk(32'h34, 32'hFFFF, 32'hFF00, "gain lo");
      wr_chk(32'h28, 32'hFFFF1234, 32'h1234, "offset up");
      wr_chk(32'h30, 32'hABCD, 32'hABCD, "gain up");
      apb(1'b1, 32'h3C, 32'hFFFF); check("unmapped err", 32'h1, err);
      apb(1'b0, 32'h3C, 32'h0); check("unmapped read", 32'h0, rd);
      $display("test_cal done");
   endtask
   task test_data;
      apb(1'b1, 32'h28, 32'h0); apb(1'b1, 32'h2C, 32'h0);
      apb(1'b1, 32'h30, 32'h8000); apb(1'b1, 32'h34, 32'h0);
      sample(24'h000100, 24'h000100);
      apb(1'b1, 32'h2C, 32'h1000); sample(24'h000100, 24'h0000F0);
      apb(1'b1, 32'h30, 32'h4000); sample(24'h000100, 24'h000078);
      sample(24'h000008, 24'hFFFFFC);
      $display("test_data done");
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clock);
      i_reset_n <= 1'b1;
      @(posedge i_clock);
      test_reset; test_setup; test_cal; test_data;
      tally_and_finish;
   end
   initial begin
      #400000;
      failures++;
      tally_and_finish;
   end
endmodule // chan0_config_calibration_regs_tb
`default_nettype wire
